// [hw/nsc_pkg.sv]
// Package: constants and types for the die status and column select block
package nsc_pkg;
    localparam logic [7:0] CMD_STATUS     = 8'h70;
    localparam logic [7:0] CMD_STATUS_LUN = 8'h78;
    localparam logic [7:0] CMD_COL        = 8'h05;
    localparam logic [7:0] CMD_COL_ENH    = 8'h06;
    localparam logic [7:0] CMD_CONFIRM    = 8'hE0;
    localparam logic [7:0] CMD_READ_MODE  = 8'h00;
    localparam logic [7:0] CMD_RESET      = 8'hFF;
    localparam int BIT_LAST_ERR  = 0;
    localparam int BIT_PRIOR_ERR = 1;
    localparam int BIT_ARRAY_IDLE = 5;
    localparam int BIT_IO_IDLE   = 6;
    localparam int BIT_WP        = 7;
    localparam int COL_ADDR_CYCLES = 2;
    localparam int ROW_ADDR_CYCLES = 3;
    localparam int COL_WAIT_CYCLES = 8;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [1:0] {
        NSC_OUT_NONE,
        NSC_OUT_STATUS,
        NSC_OUT_DATA
    } nsc_out_mode_t;

    typedef struct packed {
        logic       cmd_valid;
        logic       addr_valid;
        logic [7:0] bus_byte;
    } nsc_bus_cycle_t;
endpackage

// [hw/nsc_status_column.sv]
// Die status reporting and read column select for one NAND die
`timescale 1ns/1ps
`default_nettype none

module nsc_status_column #(
    parameter int PLANES      = 2,
    parameter int COL_BITS    = 13,
    parameter int LUN_BITS    = 1,
    parameter int PLANE_BIT   = 8,
    parameter int LUN_BIT     = 19,
    parameter int WAIT_CYCLES = nsc_pkg::COL_WAIT_CYCLES,
    parameter logic [LUN_BITS-1:0] MY_LUN = '0
) (
    input  wire logic                       clock,
    input  wire logic                       rst,
    input  wire nsc_pkg::nsc_bus_cycle_t    bus_in,
    input  wire logic                       sync_mode,
    input  wire logic                       write_protect_n,
    input  wire logic                       io_idle,
    input  wire logic [PLANES-1:0]          plane_array_busy,
    input  wire logic [PLANES-1:0]          plane_active,
    input  wire logic [PLANES-1:0]          plane_prior_op_error,
    input  wire logic [PLANES-1:0]          plane_last_op_error,
    output logic [7:0]                      die_status_byte,
    output logic                            status_out_en,
    output logic                            data_out_en,
    output logic                            data_ready,
    output logic [COL_BITS-1:0]             column_reg,
    output logic [$clog2(PLANES)-1:0]       plane_sel_reg,
    output logic                            selected_reg
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_COL_ADDR, ST_ROW_ADDR, ST_STATUS_ROW, ST_CONFIRM
    } nsc_state_t;

    localparam int PW = $clog2(PLANES);

    nsc_state_t              state_reg;
    logic                    enh_reg;
    logic [2:0]              cnt_reg;
    logic [23:0]             row_reg;
    logic [COL_BITS-1:0]     col_tmp_reg;
    nsc_pkg::nsc_out_mode_t  mode_reg;
    logic                    per_lun_reg;
    logic [15:0]             wait_reg;
    logic                    array_idle;
    logic                    prior_op_error;
    logic                    last_op_error;
    logic [7:0]              status_next;
    logic                    is_cmd;
    logic                    is_addr;
    logic [7:0]              b;
    logic [PW-1:0]           row_plane;
    logic [LUN_BITS-1:0]     row_lun;
    logic [COL_BITS-1:0]     col_full;

    assign is_cmd  = bus_in.cmd_valid;
    assign is_addr = bus_in.addr_valid;
    assign b       = bus_in.bus_byte;
    assign row_plane = PW'(row_reg >> PLANE_BIT);
    assign row_lun   = LUN_BITS'(row_reg >> LUN_BIT);
    assign col_full  = COL_BITS'({b, col_tmp_reg[7:0]});

    assign array_idle = ~|plane_array_busy;

    // Error bits per plane or ORed
    always_comb begin
        prior_op_error = 1'b0;
        last_op_error  = 1'b0;
        if (per_lun_reg) begin
            prior_op_error = plane_prior_op_error[plane_sel_reg];
            last_op_error  = plane_last_op_error[plane_sel_reg];
        end else begin
            prior_op_error = |(plane_prior_op_error & plane_active);
            last_op_error  = |(plane_last_op_error & plane_active);
        end
    end

    always_comb begin
        status_next = nsc_pkg::STATUS_RESET;
        status_next[nsc_pkg::BIT_WP]        = write_protect_n;
        status_next[nsc_pkg::BIT_IO_IDLE]   = io_idle;
        status_next[nsc_pkg::BIT_ARRAY_IDLE] = array_idle;
        status_next[nsc_pkg::BIT_PRIOR_ERR] = prior_op_error;
        status_next[nsc_pkg::BIT_LAST_ERR]  = last_op_error;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            die_status_byte <= nsc_pkg::STATUS_RESET;
        end else begin
            die_status_byte <= status_next;
        end
    end

    // Command and address sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            enh_reg     <= 1'b0;
            cnt_reg     <= '0;
            row_reg     <= '0;
            col_tmp_reg <= '0;
        end else if (is_cmd) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
            row_reg   <= '0;
            // Per-die status accepted even when busy
            if (b == nsc_pkg::CMD_STATUS_LUN) begin
                state_reg <= ST_STATUS_ROW;
            end else if (b == nsc_pkg::CMD_COL && io_idle) begin
                state_reg <= ST_COL_ADDR;
                enh_reg   <= 1'b0;
            end else if (b == nsc_pkg::CMD_COL_ENH && io_idle && array_idle) begin
                state_reg <= ST_COL_ADDR;
                enh_reg   <= 1'b1;
            end
        end else if (is_addr) begin
            unique case (state_reg)
                ST_COL_ADDR: begin
                    cnt_reg <= cnt_reg + 3'd1;
                    if (cnt_reg == 3'd0) begin
                        col_tmp_reg[7:0] <= b;
                    end else begin
                        // Column low bit forced in sync mode
                        col_tmp_reg <= sync_mode ? (col_full & ~COL_BITS'(1)) : col_full;
                        cnt_reg     <= '0;
                        state_reg   <= enh_reg ? ST_ROW_ADDR : ST_CONFIRM;
                    end
                end
                ST_ROW_ADDR, ST_STATUS_ROW: begin
                    row_reg <= {b, row_reg[23:8]};
                    cnt_reg <= cnt_reg + 3'd1;
                    if (cnt_reg == 3'(nsc_pkg::ROW_ADDR_CYCLES - 1)) begin
                        cnt_reg   <= '0;
                        state_reg <= (state_reg == ST_ROW_ADDR) ? ST_CONFIRM : ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Completed sequences
    logic status_row_done;
    logic confirm_done;
    assign status_row_done = is_addr && state_reg == ST_STATUS_ROW
                             && cnt_reg == 3'(nsc_pkg::ROW_ADDR_CYCLES - 1);
    assign confirm_done = is_cmd && state_reg == ST_CONFIRM && b == nsc_pkg::CMD_CONFIRM;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg      <= nsc_pkg::NSC_OUT_NONE;
            per_lun_reg   <= 1'b0;
            selected_reg  <= 1'b1;
            plane_sel_reg <= '0;
            column_reg    <= '0;
        end else if (status_row_done) begin
            selected_reg  <= LUN_BITS'({b, row_reg[23:8]} >> LUN_BIT) == MY_LUN;
            plane_sel_reg <= PW'({b, row_reg[23:8]} >> PLANE_BIT);
            per_lun_reg   <= 1'b1;
            mode_reg      <= nsc_pkg::NSC_OUT_STATUS;
        end else if (confirm_done) begin
            column_reg <= col_tmp_reg;
            mode_reg   <= nsc_pkg::NSC_OUT_DATA;
            if (enh_reg) begin
                selected_reg  <= row_lun == MY_LUN;
                plane_sel_reg <= row_plane;
            end
        end else if (is_cmd && b == nsc_pkg::CMD_STATUS) begin
            per_lun_reg <= 1'b0;
            mode_reg    <= nsc_pkg::NSC_OUT_STATUS;
        end else if (is_cmd && b == nsc_pkg::CMD_READ_MODE) begin
            mode_reg <= nsc_pkg::NSC_OUT_DATA;
        end else if (is_cmd && b != nsc_pkg::CMD_STATUS_LUN && b != nsc_pkg::CMD_COL
                     && b != nsc_pkg::CMD_COL_ENH && b != nsc_pkg::CMD_CONFIRM) begin
            mode_reg <= nsc_pkg::NSC_OUT_NONE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wait_reg <= '0;
        end else if (confirm_done) begin
            wait_reg <= 16'(WAIT_CYCLES);
        end else if (wait_reg != 16'h0000) begin
            wait_reg <= wait_reg - 16'h0001;
        end
    end

    assign status_out_en = selected_reg && mode_reg == nsc_pkg::NSC_OUT_STATUS;
    assign data_out_en   = selected_reg && mode_reg == nsc_pkg::NSC_OUT_DATA;
    assign data_ready    = data_out_en && wait_reg == 16'h0000;

    property p_reserved_zero;
        @(posedge clock) disable iff (rst) die_status_byte[4:2] == 3'b000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");

    property p_array_idle;
        @(posedge clock) disable iff (rst)
            |plane_array_busy |=> !die_status_byte[nsc_pkg::BIT_ARRAY_IDLE];
    endproperty
    a_array_idle: assert property (p_array_idle) else $error("array idle wrong");

    property p_io_idle;
        @(posedge clock) disable iff (rst)
            1'b1 |=> die_status_byte[nsc_pkg::BIT_IO_IDLE] == $past(io_idle);
    endproperty
    a_io_idle: assert property (p_io_idle) else $error("io idle wrong");

    property p_or_errors;
        @(posedge clock) disable iff (rst)
            !per_lun_reg |=> die_status_byte[0] == $past(|(plane_last_op_error & plane_active));
    endproperty
    a_or_errors: assert property (p_or_errors) else $error("OR of errors wrong");

    property p_prior_err;
        @(posedge clock) disable iff (rst)
            per_lun_reg |=> die_status_byte[1] == $past(plane_prior_op_error[plane_sel_reg]);
    endproperty
    a_prior_err: assert property (p_prior_err) else $error("plane prior error wrong");

    property p_last_err;
        @(posedge clock) disable iff (rst)
            per_lun_reg |=> die_status_byte[0] == $past(plane_last_op_error[plane_sel_reg]);
    endproperty
    a_last_err: assert property (p_last_err) else $error("plane last error wrong");

    property p_status_lun;
        @(posedge clock) disable iff (rst)
            status_row_done |=> per_lun_reg && mode_reg == nsc_pkg::NSC_OUT_STATUS;
    endproperty
    a_status_lun: assert property (p_status_lun) else $error("per-die status not entered");

    property p_sync_align;
        @(posedge clock) disable iff (rst)
            confirm_done && sync_mode && $past(sync_mode) |=> !column_reg[0];
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("column lsb not zero");

    property p_wait;
        @(posedge clock) disable iff (rst) confirm_done |=> !data_ready;
    endproperty
    a_wait: assert property (p_wait) else $error("data ready too early");

    property p_enh_ready;
        @(posedge clock) disable iff (rst)
            is_cmd && b == nsc_pkg::CMD_COL_ENH && !array_idle |=> state_reg == ST_IDLE;
    endproperty
    a_enh_ready: assert property (p_enh_ready) else $error("enhanced taken while busy");

    property p_col_refused;
        @(posedge clock) disable iff (rst)
            is_cmd && b == nsc_pkg::CMD_COL && !io_idle |=> state_reg == ST_IDLE;
    endproperty
    a_col_refused: assert property (p_col_refused) else $error("col taken busy");

    property p_enh_plane;
        @(posedge clock) disable iff (rst)
            confirm_done && enh_reg |=> plane_sel_reg == $past(PW'(row_reg >> PLANE_BIT));
    endproperty
    a_enh_plane: assert property (p_enh_plane) else $error("plane not taken");

    property p_plain_sel;
        @(posedge clock) disable iff (rst)
            is_cmd && b == nsc_pkg::CMD_STATUS |=> !per_lun_reg && selected_reg == $past(selected_reg);
    endproperty
    a_plain_sel: assert property (p_plain_sel) else $error("plain status moved selection");

    c_status: cover property (@(posedge clock) status_row_done);
    c_col: cover property (@(posedge clock) confirm_done && !enh_reg);
    c_enh: cover property (@(posedge clock) confirm_done && enh_reg);
    c_deselect: cover property (@(posedge clock) $fell(selected_reg));
    c_ready: cover property (@(posedge clock) $rose(data_ready));
endmodule

`default_nettype wire

// [testbench/nsc_host_model.sv]
// Host flash controller model that issues command and address cycles
`timescale 1ns/1ps
`default_nettype none

module nsc_host_model (
    input  wire logic                     clock,
    output var  nsc_pkg::nsc_bus_cycle_t  bus_out
);
    initial bus_out = '0;

    // One bus cycle, driven after a falling edge and held for one clock
    task automatic cyc(input logic c, input logic [7:0] b);
        @(negedge clock);
        bus_out <= '{cmd_valid: c, addr_valid: !c, bus_byte: b};
        @(negedge clock);
        bus_out <= '0;
    endtask

    // three row cycles, low byte first
    task automatic rows(input logic [23:0] r);
        cyc(1'b0, r[7:0]);
        cyc(1'b0, r[15:8]);
        cyc(1'b0, r[23:16]);
    endtask

    task automatic status();
        cyc(1'b1, nsc_pkg::CMD_STATUS);
    endtask

    task automatic status_lun(input logic [23:0] r);
        cyc(1'b1, nsc_pkg::CMD_STATUS_LUN);
        rows(r);
    endtask

    task automatic col(input logic [12:0] c);
        cyc(1'b1, nsc_pkg::CMD_COL);
        cyc(1'b0, c[7:0]);
        cyc(1'b0, {3'h0, c[12:8]});
        cyc(1'b1, nsc_pkg::CMD_CONFIRM);
    endtask

    // two column, three row cycles, confirm
    task automatic col_enh(input logic [12:0] c, input logic [23:0] r);
        cyc(1'b1, nsc_pkg::CMD_COL_ENH);
        cyc(1'b0, c[7:0]);
        cyc(1'b0, {3'h0, c[12:8]});
        rows(r);
        cyc(1'b1, nsc_pkg::CMD_CONFIRM);
    endtask
endmodule

`default_nettype wire

// [testbench/tb.sv]
// Testbench for the die status and column select block
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int W = 4;
    logic                    clock, rst, sync_mode, write_protect_n, io_idle;
    logic [1:0]              busy, act, perr, lerr;
    logic [7:0]              sb;
    logic                    st_en, dat_en, rdy, sel;
    logic [12:0]             col;
    logic [0:0]              pl;
    nsc_pkg::nsc_bus_cycle_t bus;
    int                      error_cnt = 0;
    int                      num_checks = 0;

    nsc_host_model i_host (.clock(clock), .bus_out(bus));

    nsc_status_column #(.PLANES(2), .WAIT_CYCLES(W)) i_dut (
        .clock(clock), .rst(rst), .bus_in(bus), .sync_mode(sync_mode),
        .write_protect_n(write_protect_n), .io_idle(io_idle),
        .plane_array_busy(busy), .plane_active(act), .plane_prior_op_error(perr),
        .plane_last_op_error(lerr), .die_status_byte(sb), .status_out_en(st_en),
        .data_out_en(dat_en), .data_ready(rdy), .column_reg(col),
        .plane_sel_reg(pl), .selected_reg(sel));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: status %h, want %h", $time, g, e);
        end
    endtask

    task automatic chk_flag(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b, want %b", $time, g, e);
        end
    endtask

    task automatic chk_col(input logic [12:0] g, input logic [12:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: column %h, want %h", $time, g, e);
        end
    endtask

    // Set die state at a falling edge and let the status byte follow
    task automatic die(input logic io, input logic [1:0] b, a, p, l);
        io_idle = io;
        busy = b;
        act = a;
        perr = p;
        lerr = l;
        @(negedge clock);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        error_cnt++;
        $display("unexpected at %0t: run did not finish", $time);
        final_report();
    end

    initial begin
        rst = 1'b1;
        sync_mode = 1'b0;
        write_protect_n = 1'b1;
        io_idle = 1'b1;
        busy = 2'h0;
        act = 2'h3;
        perr = 2'h0;
        lerr = 2'h0;
        repeat (12) @(negedge clock);
        rst = 1'b0;
        chk_byte(sb, 8'h00);
        chk_flag(sel, 1'b1);
        chk_col(col, 13'h0000);
        // Plain status, ORed planes, idle then busy
        die(1'b1, 2'h0, 2'h3, 2'b10, 2'b01);
        i_host.status();
        chk_flag(st_en, 1'b1);
        chk_byte(sb, 8'hE3);
        die(1'b0, 2'b01, 2'b01, 2'b10, 2'b01);
        chk_byte(sb, 8'h81);
        write_protect_n = 1'b0;
        die(1'b1, 2'b10, 2'h3, 2'b00, 2'b00);
        chk_byte(sb, 8'h40);
        write_protect_n = 1'b1;
        $display("test plain_status done");
        // Per-plane status, then leaving the bus
        die(1'b1, 2'h0, 2'h3, 2'b10, 2'b01);
        for (int p = 0; p < 2; p++) begin
            i_host.status_lun(24'(p) << 8);
            @(negedge clock);
            chk_byte(sb, {3'b111, 3'b000, perr[p], lerr[p]});
            chk_flag(pl[0], p[0]);
        end
        i_host.status_lun(24'h080000);
        chk_flag(sel, 1'b0);
        chk_flag(st_en, 1'b0);
        i_host.status_lun(24'h000000);
        i_host.cyc(1'b1, nsc_pkg::CMD_READ_MODE);
        chk_flag(dat_en, 1'b1);
        i_host.status();
        @(negedge clock);
        chk_byte(sb, 8'hE3);
        i_host.cyc(1'b1, nsc_pkg::CMD_RESET);
        chk_flag(st_en, 1'b0);
        $display("test lun_status done");
        // Column change, wait, alignment, cache read, refusal
        die(1'b1, 2'h0, 2'h3, 2'h0, 2'h0);
        i_host.status_lun(24'h000000);
        i_host.col(13'h1FFF);
        chk_col(col, 13'h1FFF);
        chk_flag(dat_en, 1'b1);
        repeat (W - 1) @(negedge clock);
        chk_flag(rdy, 1'b0);
        @(negedge clock);
        chk_flag(rdy, 1'b1);
        sync_mode = 1'b1;
        i_host.col(13'h0155);
        chk_col(col, 13'h0154);
        sync_mode = 1'b0;
        die(1'b1, 2'b01, 2'h3, 2'h0, 2'h0);
        i_host.col(13'h0ABC);
        chk_col(col, 13'h0ABC);
        die(1'b0, 2'b01, 2'h3, 2'h0, 2'h0);
        i_host.col(13'h0123);
        chk_col(col, 13'h0ABC);
        $display("test column_change done");
        // Enhanced change picks plane and die
        die(1'b1, 2'b01, 2'h3, 2'h0, 2'h0);
        i_host.status_lun(24'h000000);
        i_host.col_enh(13'h0077, 24'h000100);
        chk_col(col, 13'h0ABC);
        chk_flag(pl[0], 1'b0);
        chk_flag(dat_en, 1'b0);
        die(1'b1, 2'h0, 2'h3, 2'h0, 2'h0);
        i_host.col_enh(13'h0077, 24'h000100);
        chk_col(col, 13'h0077);
        chk_flag(pl[0], 1'b1);
        chk_flag(dat_en, 1'b1);
        i_host.col_enh(13'h0010, 24'h000000);
        chk_flag(pl[0], 1'b0);
        i_host.col_enh(13'h0020, 24'h080000);
        chk_flag(sel, 1'b0);
        chk_flag(dat_en, 1'b0);
        $display("test enhanced_column done");
        // Reset again in mid-run from a deselected data state
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        chk_byte(sb, 8'h00);
        chk_flag(sel, 1'b1);
        chk_flag(dat_en, 1'b0);
        chk_col(col, 13'h0000);
        die(1'b1, 2'h0, 2'h3, 2'h0, 2'h0);
        chk_byte(sb, 8'hE0);
        $display("test mid_reset done");
        final_report();
    end
endmodule

`default_nettype wire
